/* hw/uft_tx.sv */
// Purpose: Frame-format transmitter with one transmit buffer, APB registers.
// Assumes: Pin inputs are asynchronous; gpio drive comes from pclk logic.
// Notes: Changing the frame format mid-frame corrupts that frame.
module uft_tx
    import uft_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gpio_out_i,
    input wire logic gpio_oe_n_i,
    output logic serial_out_o,
    output logic serial_out_oe_n,
    input wire logic xck_i,
    output logic xck_o,
    output logic xck_oe_n
);

    logic [UFT_CTRL_W-1:0] ctrl_ff;
    logic [UFT_BAUD_W-1:0] baud_ff;
    logic [8:0] buf_ff;
    logic buf_full_ff;
    logic done_ff;
    logic [8:0] shift_ff;
    logic par_ff;
    logic [3:0] left_ff;
    logic [4:0] phase_ff;
    logic txd_ff;
    logic pin_ff;
    logic pin_oe_n_ff;
    logic xck_ff;
    logic xck_oe_n_ff;
    logic xck_d_ff;
    logic [31:0] rdata_ff;
    logic err_ff;
    logic xck_s;
    logic tick;
    logic step;
    logic load;
    logic frame_end;
    logic wr_acc;
    logic wr_data;
    logic baud_restart;
    logic [4:0] ovs;
    logic [3:0] nbits;
    logic [8:0] mask;
    logic [8:0] masked;
    logic busy;
    logic active;
    logic slave_clk;
    uft_cfg_t cfg;
    uft_state_t st_ff;
    uft_state_t nxt_st;

    assign cfg = uft_cfg_t'(ctrl_ff);
    assign pready = 1'b1;
    assign pslverr = err_ff;
    assign prdata = rdata_ff;
    assign serial_out_o = pin_ff;
    assign serial_out_oe_n = pin_oe_n_ff;
    assign xck_o = xck_ff;
    assign xck_oe_n = xck_oe_n_ff;

    // The transfer clock pin is foreign to pclk and is synchronised first.
    uft_sync2 #(.W(1)) u_xck_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_i(xck_i),
        .sync_o(xck_s)
    );

    uft_baud #(.W(UFT_BAUD_W)) u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .baud_divisor(baud_ff),
        .reload(baud_restart),
        .tick(tick)
    );

    // Writes take effect only in the access phase; the slave never waits.
    assign wr_acc = psel && penable && pwrite;
    // Data writes are dropped while disabled so nothing sits unsent.
    assign wr_data = wr_acc && paddr == UFT_DATA_OFS && cfg.tx_enable_bit;
    // An async frame from idle restarts the divider, or its start bit could run short.
    // The term avoids load itself, which would loop back through tick and step.
    assign baud_restart = (wr_acc && paddr == UFT_BAUD_OFS) ||
                          (buf_full_ff && st_ff == UFT_IDLE && !cfg.sync_mode);
    assign slave_clk = cfg.sync_mode && !cfg.clk_master;

    // Data bit count from the size code; reserved codes act as eight bits.
    always_comb
    begin
        if (cfg.char_size_sel == UFT_CSZ_NINE)
            nbits = UFT_BITS_NINE;
        else if (cfg.char_size_sel[2])
            nbits = UFT_BITS_EIGHT;
        else
            nbits = UFT_BITS_BASE + {2'b00, cfg.char_size_sel[1:0]};
        mask = 9'h1FF >> (4'h9 - nbits);
        masked = buf_ff & mask;
    end

    // Ticks per bit by mode; double speed has no meaning in sync mode.
    always_comb
    begin
        if (cfg.sync_mode)
            ovs = UFT_OVS_SYNC;
        else if (cfg.double_speed_sel)
            ovs = UFT_OVS_DBL;
        else
            ovs = UFT_OVS_NORM;
    end

    // Bit boundary: last tick of a bit, or the change edge of an external clock.
    always_comb
    begin
        if (slave_clk)
            step = (xck_s != xck_d_ff) && (xck_s != cfg.clock_polarity_sel);
        else
            step = tick && (phase_ff == ovs - 5'h01);
    end

    assign busy = (st_ff != UFT_IDLE);
    assign frame_end = step && ((st_ff == UFT_STOP1 && !cfg.stop_bits_sel) ||
                                st_ff == UFT_STOP2);
    // Async frames may start any cycle; sync frames wait for a change edge.
    assign load = buf_full_ff && ((st_ff == UFT_IDLE && (step || !cfg.sync_mode)) ||
                                  frame_end);
    // Disable only bites once the shifter and buffer are both empty.
    assign active = cfg.tx_enable_bit || busy || buf_full_ff;

    // Remember the last synced clock level for edge detection.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            xck_d_ff <= 1'b0;
        else
            xck_d_ff <= xck_s;
    end

    // Phase count within a bit restarts with each async frame start.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_ff <= 5'h00;
        else if (load && !cfg.sync_mode)
            phase_ff <= 5'h00;
        else if (step)
            phase_ff <= 5'h00;
        else if (tick)
            phase_ff <= phase_ff + 5'h01;
    end

    // Master clock leaves its idle level at the change edge, returns mid-bit.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            xck_ff <= 1'b0;
        else if (!(cfg.sync_mode && cfg.clk_master))
            xck_ff <= cfg.clock_polarity_sel;
        else if (step)
            xck_ff <= !cfg.clock_polarity_sel;
        else if (tick)
            xck_ff <= cfg.clock_polarity_sel;
    end

    // Control and divisor registers; the control write may also clear nothing else.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= UFT_CTRL_RST;
            baud_ff <= UFT_BAUD_RST;
        end
        else if (wr_acc && paddr == UFT_CTRL_OFS)
            ctrl_ff <= pwdata[UFT_CTRL_W-1:0];
        else if (wr_acc && paddr == UFT_BAUD_OFS)
            baud_ff <= pwdata[UFT_BAUD_W-1:0];
    end

    // Transmit buffer: the ninth bit is captured from control at the data write.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            buf_ff <= 9'h000;
            buf_full_ff <= 1'b0;
        end
        else
        begin
            if (wr_data)
                buf_ff <= {cfg.tx_ninth_bit, pwdata[7:0]};
            // A write in the load cycle refills the buffer; the write wins.
            if (wr_data)
                buf_full_ff <= 1'b1;
            else if (load)
                buf_full_ff <= 1'b0;
        end
    end

    // Done flag: the frame-end set wins over a same-cycle write-one clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_ff <= 1'b0;
        else if (frame_end && !buf_full_ff)
            done_ff <= 1'b1;
        else if (wr_acc && paddr == UFT_STAT_OFS && pwdata[UFT_STAT_DONE])
            done_ff <= 1'b0;
    end

    // Frame sequencing; every state except idle in async mode advances only on a bit boundary.
    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            UFT_IDLE:
                if (load)
                    nxt_st = UFT_START;
            UFT_START:
                if (step)
                    nxt_st = UFT_DATA;
            UFT_DATA:
                if (step && left_ff == 4'h1)
                    nxt_st = cfg.parity_mode_sel[1] ? UFT_PAR : UFT_STOP1;
            UFT_PAR:
                if (step)
                    nxt_st = UFT_STOP1;
            UFT_STOP1:
                if (load)
                    nxt_st = UFT_START;
                else if (frame_end)
                    nxt_st = UFT_IDLE;
                else if (step)
                    nxt_st = UFT_STOP2;
            UFT_STOP2:
                if (load)
                    nxt_st = UFT_START;
                else if (step)
                    nxt_st = UFT_IDLE;
            default:
                nxt_st = UFT_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= UFT_IDLE;
        else
            st_ff <= nxt_st;
    end

    // Shifter: parity is fixed at load from the masked character.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_ff <= 9'h000;
            par_ff <= 1'b0;
            left_ff <= 4'h0;
        end
        else if (load)
        begin
            shift_ff <= masked;
            par_ff <= (^masked) ^ (cfg.parity_mode_sel == UFT_PM_ODD);
            left_ff <= nbits;
        end
        else if (step && st_ff == UFT_DATA)
        begin
            shift_ff <= shift_ff >> 1;
            left_ff <= left_ff - 4'h1;
        end
    end

    // Line level per state; idle and stop bits stay high.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            txd_ff <= 1'b1;
        else
        begin
            case (nxt_st)
                UFT_START:
                    txd_ff <= 1'b0;
                UFT_DATA:
                    txd_ff <= (st_ff == UFT_DATA && step) ? shift_ff[1] : shift_ff[0];
                UFT_PAR:
                    txd_ff <= par_ff;
                default:
                    txd_ff <= 1'b1;
            endcase
        end
    end

    // Pin ownership: the transmitter overrides gpio while it is active.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_ff <= 1'b1;
            pin_oe_n_ff <= 1'b1;
            xck_oe_n_ff <= 1'b1;
        end
        else
        begin
            pin_ff <= active ? txd_ff : gpio_out_i;
            pin_oe_n_ff <= active ? 1'b0 : gpio_oe_n_i;
            xck_oe_n_ff <= !(active && cfg.sync_mode && cfg.clk_master);
        end
    end

    // Read data and error are latched in the setup cycle, valid in access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_ff <= 32'h00000000;
            err_ff <= 1'b0;
        end
        else if (psel && !penable)
        begin
            rdata_ff <= 32'h00000000;
            err_ff <= 1'b0;
            case (paddr)
                UFT_DATA_OFS:
                    rdata_ff[8:0] <= buf_ff;
                UFT_CTRL_OFS:
                    rdata_ff[UFT_CTRL_W-1:0] <= ctrl_ff;
                UFT_STAT_OFS:
                begin
                    rdata_ff[UFT_STAT_EMPTY] <= !buf_full_ff;
                    rdata_ff[UFT_STAT_DONE] <= done_ff;
                    rdata_ff[UFT_STAT_BUSY] <= busy;
                end
                UFT_BAUD_OFS:
                    rdata_ff[UFT_BAUD_W-1:0] <= baud_ff;
                default:
                    err_ff <= 1'b1;
            endcase
        end
    end

    // Checks on the transmit path.
    sequence last_stop_s;
        frame_end;
    endsequence

    sequence data_last_s;
        st_ff == UFT_DATA && step && left_ff == 4'h1;
    endsequence

    start_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        load |=> !txd_ff ##1 !pin_ff)
        else $error("start bit not driven low");

    stop_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_ff == UFT_STOP1 || st_ff == UFT_STOP2) |-> txd_ff)
        else $error("stop bit not high");

    idle_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_ff == UFT_IDLE && $past(st_ff) == UFT_IDLE && cfg.tx_enable_bit)
        |=> pin_ff && !pin_oe_n_ff)
        else $error("idle line not held high");

    parity_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
        data_last_s |=> (st_ff == UFT_PAR) == cfg.parity_mode_sel[1])
        else $error("parity bit misplaced");

    no_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
        last_stop_s and buf_full_ff |=> st_ff == UFT_START && !buf_full_ff)
        else $error("gap between back-to-back frames");

    done_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        last_stop_s and !buf_full_ff and !wr_data |=> done_ff && st_ff == UFT_IDLE)
        else $error("done flag not set after frame");

    two_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff == UFT_STOP1 && step && cfg.stop_bits_sel |=> st_ff == UFT_STOP2)
        else $error("second stop bit missing");

    buf_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_data |=> buf_full_ff && buf_ff[7:0] == $past(pwdata[7:0]))
        else $error("data write did not fill buffer");

    pin_take_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.tx_enable_bit && $past(cfg.tx_enable_bit) |-> !pin_oe_n_ff)
        else $error("serial pin not taken over");

    xck_take_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(cfg.tx_enable_bit && cfg.sync_mode && cfg.clk_master) |-> !xck_oe_n_ff)
        else $error("transfer clock pin not driven");

endmodule : uft_tx

/* inc/uft_pkg.sv */
// Purpose: Shared constants and types for the frame-format transmitter.
// Assumes: APB data is 32 bits; each register is one aligned word.
// Notes: Ctrl bit positions match the packed cfg struct, most significant bit first.
package uft_pkg;

    // Register byte addresses.
    localparam logic [7:0] UFT_DATA_OFS = 8'h00;
    localparam logic [7:0] UFT_CTRL_OFS = 8'h04;
    localparam logic [7:0] UFT_STAT_OFS = 8'h08;
    localparam logic [7:0] UFT_BAUD_OFS = 8'h0C;

    // Status field positions.
    localparam int UFT_STAT_EMPTY = 0;
    localparam int UFT_STAT_DONE = 1;
    localparam int UFT_STAT_BUSY = 2;

    // Widths and reset values.
    localparam int UFT_CTRL_W = 12;
    localparam int UFT_BAUD_W = 12;
    localparam logic [11:0] UFT_CTRL_RST = 12'h000;
    localparam logic [11:0] UFT_BAUD_RST = 12'h000;

    // Baud ticks per bit for each clocking mode.
    localparam logic [4:0] UFT_OVS_NORM = 5'h10;
    localparam logic [4:0] UFT_OVS_DBL = 5'h08;
    localparam logic [4:0] UFT_OVS_SYNC = 5'h02;

    // Character size code for nine-bit characters, parity mode codes.
    localparam logic [2:0] UFT_CSZ_NINE = 3'h7;
    localparam logic [3:0] UFT_BITS_BASE = 4'h5;
    localparam logic [3:0] UFT_BITS_EIGHT = 4'h8;
    localparam logic [3:0] UFT_BITS_NINE = 4'h9;
    localparam logic [1:0] UFT_PM_ODD = 2'h3;

    // Control register layout; the first field is the most significant bit.
    typedef struct packed {
        logic clk_master;
        logic double_speed_sel;
        logic clock_polarity_sel;
        logic sync_mode;
        logic stop_bits_sel;
        logic [1:0] parity_mode_sel;
        logic [2:0] char_size_sel;
        logic tx_ninth_bit;
        logic tx_enable_bit;
    } uft_cfg_t;

    typedef enum logic [5:0] {
        UFT_IDLE = 6'b000001,
        UFT_START = 6'b000010,
        UFT_DATA = 6'b000100,
        UFT_PAR = 6'b001000,
        UFT_STOP1 = 6'b010000,
        UFT_STOP2 = 6'b100000
    } uft_state_t;

endpackage : uft_pkg

/* hw/uft_sync2.sv */
// Purpose: Two-flop synchroniser for a level arriving from a pin.
// Assumes: The input is asynchronous to pclk.
// Notes: Only the second flop may be read by other logic.
module uft_sync2
    import uft_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // The first stage settles metastability; nothing else looks at it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule : uft_sync2

/* hw/uft_baud.sv */
// Purpose: Down-counting baud generator, one tick per divisor plus one clocks.
// Assumes: Reload pulses when software writes the divisor or an async frame starts from idle.
// Notes: A write restarts the count; uft_tx registers the divisor in that same cycle, so the old rate runs one more period.
module uft_baud
    import uft_pkg::*;
#(
    parameter int W = UFT_BAUD_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] baud_divisor,
    input wire logic reload,
    output logic tick
);

    logic [W-1:0] cnt_ff;

    // Reload on zero, on a divisor write or on an async frame start from idle; the tick marks the zero count.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_ff <= '0;
        else if (reload || cnt_ff == '0)
            cnt_ff <= baud_divisor;
        else
            cnt_ff <= cnt_ff - 1'b1;
    end

    assign tick = (cnt_ff == '0) && !reload;

endmodule : uft_baud

/* test/uft_rx_model.sv */
// Purpose: Remote receiver model that decodes frames seen on the transmit line.
// Assumes: Bits are of equal length, counted in pclk cycles set by the bench.
// Notes: Only the first stop bit is judged, so a second one is never sampled.
module uft_rx_model
(
    input wire logic pclk,
    input wire logic listen,
    input wire logic line_i,
    input wire logic [7:0] bit_clks,
    input wire logic [3:0] nbits,
    input wire logic par_en,
    output logic [8:0] rx_data,
    output logic rx_par,
    output logic rx_stop,
    output logic [31:0] rx_gap,
    output logic rx_stb
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] shift;
    time t_last;
    int i;

    // Hunts for a start bit, then samples every later bit at its middle.
    initial
    begin
        rx_stb = 1'b0;
        t_last = 0;
        forever
        begin
            @(posedge pclk);
            if (listen === 1'b1 && line_i === 1'b0) // Start bit is low
            begin
                rx_gap <= 32'($time - t_last);
                t_last = $time;
                shift = 9'h000;
                repeat (bit_clks / 2) @(posedge pclk);
                for (i = 0; i < nbits; i++)
                begin
                    repeat (bit_clks) @(posedge pclk);
                    shift[i] = line_i; // Lowest bit first
                end
                rx_par <= 1'b0;
                if (par_en)
                begin
                    repeat (bit_clks) @(posedge pclk);
                    rx_par <= line_i; // Parity follows the data
                end
                repeat (bit_clks) @(posedge pclk);
                rx_stop <= line_i; // Only the first stop is checked
                rx_data <= shift;
                rx_stb <= 1'b1;
                @(posedge pclk);
                rx_stb <= 1'b0;
            end
        end
    end
endmodule : uft_rx_model

/* test/uft_tx_tb.sv */
// Purpose: Self-checking bench for the frame-format transmitter.
// Assumes: The receiver model decodes the line; APB answers are still waited for.
// Notes: All thirty layouts run once each, spread over three bit rates, two frames back to back.
module uft_tx_tb
    import uft_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [8:0] data;
        logic par;
        logic [31:0] gap;
    } uft_exp_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat, rx_gap;
    logic gpio_out_i, gpio_oe_n_i, serial_out_o, serial_out_oe_n, xck_i, xck_o, xck_oe_n;
    logic listen, par_en, rx_par, rx_stop, rx_stb, rerr;
    logic [7:0] bit_clks;
    logic [3:0] nbits;
    logic [8:0] rx_data;
    logic [2:0] xck_div = 3'h0;
    int fails, samples_checked, k;
    uft_exp_t exp_q[$];
    uft_exp_t ex;
    uft_cfg_t cfg;

    uft_tx uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gpio_out_i(gpio_out_i), .gpio_oe_n_i(gpio_oe_n_i),
        .serial_out_o(serial_out_o), .serial_out_oe_n(serial_out_oe_n), .xck_i(xck_i),
        .xck_o(xck_o), .xck_oe_n(xck_oe_n));
    uft_rx_model partner (.pclk(pclk), .listen(listen), .line_i(serial_out_o),
        .bit_clks(bit_clks), .nbits(nbits), .par_en(par_en), .rx_data(rx_data),
        .rx_par(rx_par), .rx_stop(rx_stop), .rx_gap(rx_gap), .rx_stb(rx_stb));

    // Free-running 200 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Remote transfer clock for the slave scenario: eight pclk periods per cycle.
    always @(posedge pclk)
    begin
        xck_div <= xck_div + 3'h1;
        xck_i <= xck_div[2];
    end

    task automatic check(input logic [31:0] got, input logic [31:0] want, input string msg);
        samples_checked++;
        if (got !== want)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, msg, got, want);
        end
    endtask : check

    task automatic tally_and_finish();
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // One APB transfer; request is held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            fails++;
            tally_and_finish();
        end
    endtask : apb

    // Polls one status bit; a bound keeps a stuck flag from hanging the run.
    task automatic wait_stat(input int pos);
        int n;
        n = 0;
        rdat = 32'h0;
        while (rdat[pos] !== 1'b1 && n < 2000)
        begin
            apb(1'b0, UFT_STAT_OFS, 32'h0);
            n++;
        end
        if (n >= 2000)
        begin
            fails++;
            tally_and_finish();
        end
    endtask : wait_stat

    // Configures one layout and rate, then sends two frames with no idle between.
    task automatic send_pair(input uft_cfg_t c, input logic [11:0] div);
        logic [31:0] d;
        uft_exp_t e;
        int f, n, b, bits;
        n = (c.char_size_sel == UFT_CSZ_NINE) ? 9 : 5 + int'(c.char_size_sel);
        b = c.sync_mode ? 2 * (div + 1) : (c.double_speed_sel ? 8 : 16) * (div + 1);
        bits = 2 + n + int'(c.parity_mode_sel[1]) + int'(c.stop_bits_sel);
        bit_clks <= 8'(b);
        nbits <= 4'(n);
        par_en <= c.parity_mode_sel[1];
        apb(1'b1, UFT_BAUD_OFS, 32'(div));
        apb(1'b1, UFT_CTRL_OFS, 32'(c));
        apb(1'b1, UFT_STAT_OFS, 32'h2);
        for (f = 0; f < 2; f++)
        begin
            d = $urandom;
            e.data = {c.tx_ninth_bit, d[7:0]} & 9'((1 << n) - 1);
            e.par = c.parity_mode_sel[1] & ((^e.data) ^ (c.parity_mode_sel == UFT_PM_ODD));
            e.gap = (f == 1) ? 32'(bits * b * 5) : 32'h0;
            exp_q.push_back(e);
            apb(1'b1, UFT_DATA_OFS, d);
            if (f == 0)
                wait_stat(UFT_STAT_EMPTY);
        end
        apb(1'b0, UFT_STAT_OFS, 32'h0);
        check(32'(rdat[UFT_STAT_EMPTY]), 32'h0, "empty after write");
        wait_stat(UFT_STAT_DONE);
        check(32'(serial_out_o), 32'h1, "idle line");
        apb(1'b1, UFT_STAT_OFS, 32'h2);
        apb(1'b0, UFT_STAT_OFS, 32'h0);
        check(32'(rdat[2:0]), 32'h1, "status after clear");
    endtask : send_pair

    // Each decoded frame is matched against the oldest expectation.
    always @(posedge pclk)
    begin
        if (rx_stb === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(32'h1, 32'h0, "unexpected frame");
            else
            begin
                ex = exp_q.pop_front();
                check(32'(rx_data), 32'(ex.data), "frame data");
                check(32'(rx_par), 32'(ex.par), "parity bit");
                check(32'(rx_stop), 32'h1, "first stop");
                if (ex.gap != 0)
                    check(rx_gap, ex.gap, "frame spacing");
            end
        end
    end

    // Main sequence: reset, pin handover, refused write, all layouts, sync master.
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {gpio_out_i, gpio_oe_n_i, listen, par_en} = 4'b1100;
        bit_clks = 8'h10;
        nbits = 4'h8;
        fails = 0;
        samples_checked = 0;
        void'($urandom(10));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, UFT_STAT_OFS, 32'h0);
        check(rdat, 32'h1, "status at reset");
        apb(1'b0, 8'h10, 32'h0);
        check(32'(rerr), 32'h1, "unmapped error");
        for (k = 0; k < 4; k++)
        begin
            gpio_out_i <= 1'($urandom);
            gpio_oe_n_i <= 1'($urandom);
            repeat (3) @(posedge pclk);
            check(32'(serial_out_o), 32'(gpio_out_i), "gpio level");
            check(32'(serial_out_oe_n), 32'(gpio_oe_n_i), "gpio enable");
        end
        gpio_out_i <= 1'b1;
        apb(1'b1, UFT_DATA_OFS, 32'h5A);
        // Listen only once the line has settled high, so a random gpio low is no start.
        listen <= 1'b1;
        repeat (400) @(posedge pclk);
        apb(1'b0, UFT_STAT_OFS, 32'h0);
        check(rdat, 32'h1, "disabled write ignored");
        for (k = 0; k < 30; k++)
        begin
            cfg = '0;
            cfg.tx_enable_bit = 1'b1;
            cfg.char_size_sel = (k % 5 == 4) ? UFT_CSZ_NINE : 3'(k % 5);
            cfg.parity_mode_sel = ((k / 5) % 3 == 0) ? 2'h0 : ((k / 5) % 3 == 1) ? 2'h2 : UFT_PM_ODD;
            cfg.stop_bits_sel = 1'(k / 15);
            cfg.tx_ninth_bit = 1'($urandom);
            cfg.double_speed_sel = (k % 3 == 1);
            send_pair(cfg, (k % 3 == 2) ? 12'h001 : 12'h000);
            check(32'(serial_out_oe_n), 32'h0, "pin taken over");
        end
        cfg = '0;
        cfg.tx_enable_bit = 1'b1;
        cfg.char_size_sel = 3'h3;
        cfg.sync_mode = 1'b1;
        cfg.clk_master = 1'b1;
        send_pair(cfg, 12'h003);
        check(32'(xck_oe_n), 32'h0, "transfer clock driven");
        // The master clock changes level on every baud tick, four clocks apart here.
        k = int'(xck_o);
        repeat (4) @(posedge pclk);
        check(32'(xck_o), 32'(k == 0), "master clock toggles");
        // Slave mode, falling change edge; the remote clock gives the 8-clock bit send_pair expects.
        cfg.clk_master = 1'b0;
        cfg.clock_polarity_sel = 1'b1;
        cfg.parity_mode_sel = 2'h2;
        send_pair(cfg, 12'h003);
        check(32'(xck_oe_n), 32'h1, "slave clock not driven");
        check(32'(exp_q.size()), 32'h0, "frames missing");
        tally_and_finish();
    end
endmodule : uft_tx_tb
